// ### gla_map.svh
// Purpose: constants of the listener addressing block
// Assumes: bus bytes carried active high inside the device
// Notes:   definitions only
`ifndef GLA_MAP_SVH
`define GLA_MAP_SVH
`define GLA_UNLISTEN      8'h3F
`define GLA_LISTEN_BASE   8'h20
`define GLA_LISTEN_MASK   8'hE0
`define GLA_SDC           8'h04
`define GLA_DCL           8'h14
`define GLA_ADDR_MAX      5'h1E
`define GLA_ADDR_RESET    5'h07
`define GLA_FIFO_DEPTH    8
`endif

// ### gla_pkg.sv
// Purpose: types of the listener addressing block
// Assumes: nothing
// Notes:   packed carriers for data bytes and addressing status
package gla_pkg;
	typedef struct packed {
		logic [7:0] data;
		logic       eoi;
	} gla_byte_s;

	typedef struct packed {
		logic       listening;
		logic       addr_error;
		logic [4:0] address;
	} gla_status_s;

	typedef enum logic [2:0] {
		GLA_IDLE  = 3'b001,
		GLA_LATCH = 3'b010,
		GLA_WAIT  = 3'b100
	} gla_hs_e;
endpackage

// ### gla_fifo.sv
// Purpose: small data fifo with valid/ready on both sides
// Assumes: single clock, clock enable freezes state
// Notes:   read data come out of a register
`timescale 1ns/1ns
`default_nettype none
module gla_fifo #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 8
) (
	input  wire logic             clk,
	input  wire logic             reset,
	input  wire logic             ce,
	input  wire logic [WIDTH-1:0] in_data,
	input  wire logic             in_valid,
	output var  logic             in_ready,
	output var  logic [WIDTH-1:0] out_data,
	output var  logic             out_valid,
	input  wire logic             out_ready
);
	localparam int AW = $clog2(DEPTH);

	if (DEPTH < 2 || (1 << AW) != DEPTH)
		$error("depth must be a power of two");

	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [AW:0]      wr_reg;
	logic [AW:0]      rd_reg;
	logic             push;
	logic             pop;
	logic             stored;

	assign stored   = (wr_reg != rd_reg);
	assign in_ready = (wr_reg - rd_reg) != (AW+1)'(DEPTH);
	assign push     = ce && in_valid && in_ready;
	assign pop      = ce && stored && (!out_valid || out_ready);

	always_ff @(posedge clk)
	begin
		if (push)
			mem_reg[wr_reg[AW-1:0]] <= in_data;
	end

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			wr_reg <= '0;
			rd_reg <= '0;
		end
		else
		begin
			if (push)
				wr_reg <= wr_reg + 1'b1;
			if (pop)
				rd_reg <= rd_reg + 1'b1;
		end
	end

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			out_data  <= '0;
			out_valid <= 1'b0;
		end
		else if (ce)
		begin
			if (pop)
			begin
				out_data  <= mem_reg[rd_reg[AW-1:0]];
				out_valid <= 1'b1;
			end
			else if (out_ready)
				out_valid <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// ### gla_listener.sv
// Purpose: listener addressing and acceptor handshake of a parallel instrument bus port
// Assumes: bus lines given active high (asserted = 1); open-drain outputs via oe
// Notes:   data bytes queue in an 8-word fifo; full fifo holds off the handshake only while attention is released
//
// Summary of operation
// - addressed commands only when listen-addressed
// - listen address is primary plus 20h
// - selective clear under attention executes when addressed
// - bytes without attention are device data
`timescale 1ns/1ns
`default_nettype none
`include "gla_map.svh"
module gla_listener
	import gla_pkg::*;
#(
	parameter int DEPTH = `GLA_FIFO_DEPTH
) (
	input  wire logic              clk,
	input  wire logic              reset,
	input  wire logic              ce,
	input  wire logic [7:0]        dio_in,
	input  wire logic              atn_in,
	input  wire logic              dav_in,
	input  wire logic              eoi_in,
	input  wire logic              ifc_in,
	output logic                   nrfd_oe,
	output logic                   ndac_oe,
	input  wire logic [4:0]        addr_set,
	input  wire logic              addr_set_stb,
	output gla_status_s            status,
	output logic                   clear_pulse,
	output gla_byte_s              rx_byte,
	output logic                   rx_valid,
	input  wire logic              rx_ready
);
	if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
		$error("fifo depth must be a power of two");

	// ------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------
	logic [11:0] pin_s1_reg;
	logic [11:0] pin_s2_reg;

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			pin_s1_reg <= '0;
			pin_s2_reg <= '0;
		end
		else if (ce)
		begin
			pin_s1_reg <= {ifc_in, eoi_in, dav_in, atn_in, dio_in};
			pin_s2_reg <= pin_s1_reg;
		end
	end

	logic [7:0] dio;
	logic       atn;
	logic       dav;
	logic       eoi;
	logic       ifc;
	assign {ifc, eoi, dav, atn, dio} = pin_s2_reg;

	// ------------------------------------------------------------
	// primary address
	// ------------------------------------------------------------
	logic [4:0] addr_reg;
	logic       addr_err_reg;

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			addr_reg     <= `GLA_ADDR_RESET;
			addr_err_reg <= 1'b0;
		end
		else if (ce && addr_set_stb)
		begin
			if (addr_set > `GLA_ADDR_MAX)
				addr_err_reg <= 1'b1;
			else
			begin
				addr_reg     <= addr_set;
				addr_err_reg <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------
	// acceptor handshake
	// ------------------------------------------------------------
	gla_hs_e     hs_reg;
	logic [7:0]  byte_reg;
	logic        byte_atn_reg;
	logic        byte_eoi_reg;
	logic        take;
	logic        fifo_ready;
	logic        fifo_push;

	// no new byte while data might not fit
	assign take = dav && (atn || fifo_ready);

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			hs_reg       <= GLA_IDLE;
			byte_reg     <= '0;
			byte_atn_reg <= 1'b0;
			byte_eoi_reg <= 1'b0;
			nrfd_oe      <= 1'b1;
			ndac_oe      <= 1'b1;
		end
		else if (ce)
		begin
			case (hs_reg)
				GLA_IDLE:
				begin
					ndac_oe <= 1'b1;
					nrfd_oe <= !(atn || fifo_ready);
					if (take)
					begin
						byte_reg     <= dio;
						byte_atn_reg <= atn;
						byte_eoi_reg <= eoi;
						nrfd_oe      <= 1'b1;
						hs_reg       <= GLA_LATCH;
					end
				end
				GLA_LATCH:
				begin
					ndac_oe <= 1'b0;
					hs_reg  <= GLA_WAIT;
				end
				GLA_WAIT:
				begin
					if (!dav)
					begin
						ndac_oe <= 1'b1;
						hs_reg  <= GLA_IDLE;
					end
				end
				default:
					hs_reg <= GLA_IDLE;
			endcase
		end
	end

	// ------------------------------------------------------------
	// command decode
	// ------------------------------------------------------------
	logic listen_reg;
	logic latched;
	logic my_listen;
	assign latched   = ce && (hs_reg == GLA_LATCH);
	assign my_listen = byte_reg == (`GLA_LISTEN_BASE | {3'h0, addr_reg});

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			listen_reg <= 1'b0;
		else if (ce && ifc)
			listen_reg <= 1'b0;
		else if (latched && byte_atn_reg)
		begin
			if (byte_reg == `GLA_UNLISTEN)
				listen_reg <= 1'b0;
			else if (my_listen)
				listen_reg <= 1'b1;
		end
	end

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			clear_pulse <= 1'b0;
		else if (ce)
			clear_pulse <= latched && byte_atn_reg
				&& ((byte_reg == `GLA_SDC && listen_reg)
				|| byte_reg == `GLA_DCL);
	end

	// data bytes only while addressed and attention released
	assign fifo_push = latched && !byte_atn_reg && listen_reg;

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			status <= '{listening: 1'b0, addr_error: 1'b0, address: `GLA_ADDR_RESET};
		else if (ce)
			status <= '{listening: listen_reg, addr_error: addr_err_reg,
				address: addr_reg};
	end

	// ------------------------------------------------------------
	// data fifo
	// ------------------------------------------------------------
	gla_byte_s fifo_in;
	gla_byte_s fifo_out;
	logic      fifo_out_valid;
	logic      fifo_take;
	assign fifo_in = '{data: byte_reg, eoi: byte_eoi_reg};
	// refill the output register only when empty or being taken
	assign fifo_take = !rx_valid || rx_ready;

	gla_fifo #(
		.WIDTH ($bits(gla_byte_s)),
		.DEPTH (DEPTH)
	) u_fifo (
		.clk       (clk),
		.reset     (reset),
		.ce        (ce),
		.in_data   (fifo_in),
		.in_valid  (fifo_push),
		.in_ready  (fifo_ready),
		.out_data  (fifo_out),
		.out_valid (fifo_out_valid),
		.out_ready (fifo_take)
	);

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			rx_byte  <= '0;
			rx_valid <= 1'b0;
		end
		else if (ce && fifo_take)
		begin
			rx_byte  <= fifo_out;
			rx_valid <= fifo_out_valid;
		end
	end
endmodule
`default_nettype wire

// ### gla_listener_assertions.sv
// Purpose: port checks of the listener
// Assumes: lines active high
// Notes:   bound below
`timescale 1ns/1ns
`default_nettype none
module gla_listener_assertions
	import gla_pkg::*;
(
	input wire logic        clk,
	input wire logic        reset,
	input wire logic        atn_in,
	input wire logic        dav_in,
	input wire logic        nrfd_oe,
	input wire logic        ndac_oe,
	input wire logic [4:0]  addr_set,
	input wire logic        addr_set_stb,
	input wire gla_status_s status,
	input wire logic        clear_pulse,
	input wire gla_byte_s   rx_byte,
	input wire logic        rx_valid,
	input wire logic        rx_ready
);
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	hs_order_a: assert property ($fell(ndac_oe) |-> $past(nrfd_oe))
		else $error("early accept");
	hs_end_a: assert property (!ndac_oe && $fell(dav_in) |-> ##[1:4] ndac_oe)
		else $error("accept stuck");
	cmd_take_a: assert property ($rose(dav_in) && atn_in && !nrfd_oe |-> ##[1:4] nrfd_oe)
		else $error("command not taken");
	clear_cmd_a: assert property (clear_pulse |-> $past(atn_in) ##1 !clear_pulse)
		else $error("bad clear");
	listen_cmd_a: assert property ($rose(status.listening) |-> $past(atn_in, 2))
		else $error("bad listen");
	addr_bad_a: assert property (addr_set_stb && addr_set > 5'h1E |=> ##2
		status.addr_error && status.address == $past(status.address, 3))
		else $error("bad address taken");
	addr_ok_a: assert property (addr_set_stb && addr_set <= 5'h1E |=> ##2
		!status.addr_error && status.address == $past(addr_set, 3))
		else $error("good address lost");
	rx_hold_a: assert property (rx_valid && !rx_ready |=> rx_valid)
		else $error("byte withdrawn");
	rx_keep_a: assert property (rx_valid && !rx_ready |=> $stable(rx_byte))
		else $error("byte changed while offered");
	cover property (clear_pulse);
	cover property (rx_valid && rx_ready);
	cover property (status.addr_error);
endmodule
bind gla_listener gla_listener_assertions i_chk (.clk(clk), .reset(reset), .atn_in(atn_in),
	.dav_in(dav_in), .nrfd_oe(nrfd_oe), .ndac_oe(ndac_oe), .addr_set(addr_set),
	.addr_set_stb(addr_set_stb), .status(status), .clear_pulse(clear_pulse),
	.rx_byte(rx_byte), .rx_valid(rx_valid), .rx_ready(rx_ready));
`default_nettype wire

// ### gla_ctrl_model.sv
// Purpose: bus controller model
// Assumes: lines active high
// Notes:   gap adds random delay
`timescale 1ns/1ns
`default_nettype none
module gla_ctrl_model (
	input  wire logic       clk,
	input  wire logic       nrfd_oe,
	input  wire logic       ndac_oe,
	output var  logic [7:0] dio,
	output var  logic       atn,
	output var  logic       dav,
	output var  logic       eoi
);
	int gap = 0;
	int stalls = 0;
	initial {dio, atn, dav, eoi} = 11'h000;
	task automatic send(input logic [7:0] b, input logic a, input logic e);
		int n;
		repeat ($urandom_range(gap)) @(posedge clk);
		for (n = 0; n < 400 && nrfd_oe !== 1'b0; n++) @(posedge clk);
		stalls += (n == 400);
		{dio, atn, eoi, dav} <= {b, a, e, 1'b1};
		@(posedge clk);
		for (n = 0; n < 400 && ndac_oe !== 1'b0; n++) @(posedge clk);
		stalls += (n == 400);
		{dio, eoi, dav} <= {~b, ~e, 1'b0};
	endtask
endmodule
`default_nettype wire

// ### gla_listener_test.sv
// Purpose: self-checking bench of the listener
// Assumes: controller model on the bus
// Notes:   queues predict bytes, a counter predicts clears
`timescale 1ns/1ns
`default_nettype none
module gla_listener_test
	import gla_pkg::*;
;
	logic        clk = 0, reset = 1, ce = 1, ifc_in = 0, addr_set_stb = 0, rx_ready = 1;
	logic [4:0]  addr_set = 0, exp_addr = 7;
	logic        exp_listen = 0, exp_err = 0;
	wire  [7:0]  dio;
	wire         atn, dav, eoi, nrfd_oe, ndac_oe, clear_pulse, rx_valid;
	gla_status_s status;
	gla_byte_s   rx_byte, exp_q[$], got_q[$];
	int          bad_count = 0, num_checks = 0, clears = 0, exp_clears = 0;
	gla_listener i_dut (.clk(clk), .reset(reset), .ce(ce), .dio_in(dio), .atn_in(atn),
		.dav_in(dav), .eoi_in(eoi), .ifc_in(ifc_in), .nrfd_oe(nrfd_oe), .ndac_oe(ndac_oe),
		.addr_set(addr_set), .addr_set_stb(addr_set_stb), .status(status),
		.clear_pulse(clear_pulse), .rx_byte(rx_byte), .rx_valid(rx_valid), .rx_ready(rx_ready));
	gla_ctrl_model i_ctrl (.clk(clk), .nrfd_oe(nrfd_oe), .ndac_oe(ndac_oe), .dio(dio),
		.atn(atn), .dav(dav), .eoi(eoi));
	always #25 clk = ~clk;
	always @(posedge clk)
	begin
		clears += (clear_pulse === 1'b1);
		if (rx_valid === 1'b1 && rx_ready === 1'b1)
			got_q.push_back(rx_byte);
	end
	task automatic fail(input string m);
		bad_count++;
		$display("BAD %0t %s", $time, m);
	endtask
	task automatic chk_s();
		num_checks++;
		if (status !== {exp_listen, exp_err, exp_addr})
			fail("status");
	endtask
	// byte results against the queue model, clears against the expected count
	task automatic drain();
		for (int n = 0; n < 400 && got_q.size() < exp_q.size(); n++) @(posedge clk);
		repeat (8) @(posedge clk);
		num_checks += 2 + exp_q.size();
		if (clears != exp_clears || got_q.size() != exp_q.size() || i_ctrl.stalls != 0)
			fail("count");
		while (exp_q.size() > 0 && got_q.size() > 0)
			if (got_q.pop_front() !== exp_q.pop_front())
				fail("byte");
		exp_q.delete();
		got_q.delete();
	endtask
	task automatic bus(input logic [7:0] b, input logic a, input logic e);
		if (a && b == 8'h3F)
			exp_listen = 0;
		else if (a && b == 8'h20 + exp_addr)
			exp_listen = 1;
		else if (a && b == 8'h04)
			exp_clears += exp_listen;
		else if (a && b == 8'h14)
			exp_clears++;
		else if (!a && exp_listen)
			exp_q.push_back({b, e});
		i_ctrl.send(b, a, e);
	endtask
	task automatic set_addr(input logic [4:0] a);
		addr_set <= a;
		addr_set_stb <= 1;
		@(posedge clk);
		addr_set_stb <= 0;
		exp_err = a > 5'h1E;
		exp_addr = exp_err ? exp_addr : a;
		repeat (3) @(posedge clk);
		chk_s();
	endtask
	task automatic summarize();
		$display("checks %0d bad %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	initial
	begin
		#(30000 * 50);
		fail("timeout");
		summarize();
	end
	initial
	begin
		void'($urandom(32'hC25C));
		repeat (3) @(posedge clk);
		reset <= 0;
		@(posedge clk);
		chk_s();
		bus(8'h3F, 1, 0);
		bus(8'h2A, 1, 0);
		bus(8'h04, 1, 0);
		bus(8'h14, 1, 0);
		bus(8'h52, 0, 0);
		drain();
		$display("unaddressed done");
		set_addr(5'h1F);
		set_addr(5'h1E);
		set_addr(5'($urandom_range(31)));
		set_addr(5'h07);
		$display("address done");
		bus(8'h3F, 1, 0);
		bus(8'h27, 1, 0);
		bus(8'h04, 1, 0);
		i_ctrl.gap = 3;
		bus(8'h2A, 0, 0);
		bus(8'h52, 0, 0);
		bus(8'h53, 0, 0);
		bus(8'h54, 0, 1);
		drain();
		chk_s();
		$display("addressed done");
		ifc_in <= 1;
		repeat (4) @(posedge clk);
		ifc_in <= 0;
		exp_listen = 0;
		repeat (3) @(posedge clk);
		chk_s();
		bus(8'h04, 1, 0);
		bus(8'h52, 0, 0);
		drain();
		bus(8'h27, 1, 0);
		$display("interface clear done");
		rx_ready <= 0;
		fork
			repeat (12) bus(8'($urandom), 0, 1'($urandom));
		join_none
		repeat (300) @(posedge clk);
		num_checks++;
		if (nrfd_oe !== 1'b1)
			fail("full not refused");
		repeat (60) @(posedge clk) rx_ready <= 1'($urandom);
		rx_ready <= 1;
		wait fork;
		drain();
		$display("fill done");
		summarize();
	end
endmodule
`default_nettype wire
